// [design/scec_top.sv]
// Purpose: Power-up and power-down control of transmit, receive and observation chains.
// Assumes: All inputs synchronous to ref_clk_i; mask write is a one-cycle strobe.
// Notes: Enables are registered, so they follow pins one clock later and mask or source writes two clocks later.
`include "scec_consts.svh"

// Behaviour
// [RULE1] Masks are ORed codes enabling set paths
// [RULE2] Mask enables hold until next write
// [RULE3] All-off receive code disables receive, observation
// [RULE4] Code enables loopback of transmit one/two
// [RULE5] Code enables loopback of transmit three/four
// [RULE6] Transmit mask: off, singles, all-on
// [RULE7] Pin control: chain follows its pin
// [RULE8] One-pin: first pin enables preselected input
// [RULE9] Two-pin: second pin picks preassigned input
// [RULE10] Three-pin: select zero picks input one
// [RULE11] Selects one, two, three pick inputs two-four
// [RULE12] Pins ignored in register control; writes ignored otherwise
// [RULE13] Register control after reset
// [RULE14] Dual two-pin: first, third enable preassigned inputs
// [RULE15] Dual four-pin: enables plus selects, four inputs
module scec_top
  import scec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic mask_write_i,
  input wire logic [11:0] receive_path_mask_i,
  input wire logic [3:0] transmit_path_mask_i,
  input wire logic src_write_i,
  input wire scec_src_t src_i,
  input wire scec_obs_mode_t obs_mode_i,
  input wire scec_obs_pre_t obs_pre_i,
  input wire scec_pins_t pins_i,
  output scec_enables_t enables_o,
  output scec_src_t src_o,
  output logic [11:0] receive_path_mask_o,
  output logic [3:0] transmit_path_mask_o,
  output logic pin_control_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [11:0] rx_mask;
  logic [11:0] next_rx_mask;
  logic [3:0] tx_mask;
  logic [3:0] next_tx_mask;
  scec_src_t src;
  scec_src_t next_src;
  scec_state_t state;
  scec_state_t next_state;
  scec_enables_t enables;
  scec_enables_t next_enables;
  logic [3:0] obs_pin_en;

  // ----------------------------------------
  // Observation pin decode
  // ----------------------------------------
  scec_obs_pin_decode u_obs_decode (
    .mode_i(obs_mode_i),
    .pre_i(obs_pre_i),
    .pin_first_i(pins_i.obs_ctrl_pin_first),
    .pin_second_i(pins_i.obs_ctrl_pin_second),
    .pin_third_i(pins_i.obs_ctrl_pin_third),
    .pin_fourth_i(pins_i.obs_ctrl_pin_fourth),
    .obs_en_o(obs_pin_en)
  );

  // ----------------------------------------
  // Control source and masks
  // ----------------------------------------
  always_comb
  begin
    next_src = src;
    next_rx_mask = rx_mask;
    next_tx_mask = tx_mask;
    if (src_write_i)
    begin
      next_src = src_i;
    end
    // Masks held between writes; a write only reaches register-controlled groups
    if (mask_write_i)
    begin
      if (!src.rx_pin)
      begin
        next_rx_mask[3:0] = receive_path_mask_i[3:0]; // [RULE2] [RULE12]
      end
      // Observation bits follow the observation group's own source
      if (!src.obs_pin)
      begin
        next_rx_mask[11:4] = receive_path_mask_i[11:4]; // [RULE2] [RULE12]
      end
      if (!src.tx_pin)
      begin
        next_tx_mask = transmit_path_mask_i; // [RULE2] [RULE12]
      end
    end
    next_state = (next_src == 3'b000) ? SCEC_ST_REG : SCEC_ST_MIXED;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      src <= 3'b000; // [RULE13]
      state <= SCEC_ST_REG; // [RULE13]
      rx_mask <= `SCEC_RX_MASK_RESET;
      tx_mask <= `SCEC_TX_MASK_RESET;
    end
    else
    begin
      src <= next_src;
      state <= next_state;
      rx_mask <= next_rx_mask;
      tx_mask <= next_tx_mask;
    end
  end

  // ----------------------------------------
  // Path enables
  // ----------------------------------------
  always_comb
  begin
    next_enables = '0;
    // Each set code bit enables exactly its path; all-off leaves all clear
    if (src.rx_pin)
    begin
      next_enables.rx = pins_i.rx_en; // [RULE7] [RULE12]
    end
    else
    begin
      next_enables.rx = rx_mask[`SCEC_RX1_BIT +: 4]; // [RULE1] [RULE3]
    end
    if (src.tx_pin)
    begin
      next_enables.tx = pins_i.tx_en; // [RULE7] [RULE12]
    end
    else
    begin
      next_enables.tx = tx_mask; // [RULE1] [RULE6]
    end
    if (src.obs_pin)
    begin
      next_enables.obs = obs_pin_en; // [RULE12]
    end
    else
    begin
      next_enables.obs = rx_mask[`SCEC_ORX1_BIT +: 4]; // [RULE1] [RULE3]
      next_enables.loopback[0] = rx_mask[`SCEC_LB12_BIT]; // [RULE4]
      next_enables.loopback[1] = rx_mask[`SCEC_LB34_BIT]; // [RULE5]
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      enables <= '0;
    end
    else
    begin
      enables <= next_enables;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb
  begin
    enables_o = enables;
    src_o = src;
    receive_path_mask_o = rx_mask;
    transmit_path_mask_o = tx_mask;
    // One-hot: the mixed-state bit is the flag itself
    pin_control_o = state[1];
  end

endmodule

// [inc/scec_consts.svh]
// Purpose: Constants for the signal chain enable control block.
// Assumes: Included by its bare name from design files.
// Notes: Receive mask codes are one-hot, ORed by software.
`ifndef SCEC_CONSTS_SVH
`define SCEC_CONSTS_SVH

// ----------------------------------------
// Receive-side mask codes
// ----------------------------------------
`define SCEC_RX_ALL_OFF_CODE 12'h000
`define SCEC_RX1_BIT 0
`define SCEC_ORX1_BIT 4
`define SCEC_LB12_BIT 8
`define SCEC_LB34_BIT 9

// ----------------------------------------
// Transmit-side mask codes
// ----------------------------------------
`define SCEC_TX_ALL_OFF_CODE 4'h0
`define SCEC_TX_ALL_ON_CODE 4'hF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCEC_RX_MASK_RESET 12'h000
`define SCEC_TX_MASK_RESET 4'h0
`define SCEC_MODE_RESET 1'b0

`endif

// [inc/scec_pkg.sv]
// Purpose: Types for the signal chain enable control block.
// Assumes: Nothing beyond the constants header.
// Notes: Observation modes are plain enumerations.
package scec_pkg;

  // ----------------------------------------
  // Observation pin modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SCEC_OBS_SINGLE_1PIN = 3'h0,
    SCEC_OBS_SINGLE_2PIN = 3'h1,
    SCEC_OBS_SINGLE_3PIN = 3'h2,
    SCEC_OBS_DUAL_2PIN = 3'h3,
    SCEC_OBS_DUAL_4PIN = 3'h4
  } scec_obs_mode_t;

  // Control pins from the baseband controller
  typedef struct packed {
    logic [3:0] rx_en;
    logic [3:0] tx_en;
    logic obs_ctrl_pin_first;
    logic obs_ctrl_pin_second;
    logic obs_ctrl_pin_third;
    logic obs_ctrl_pin_fourth;
  } scec_pins_t;

  // Per-group control source: 1 = pin control
  typedef struct packed {
    logic tx_pin;
    logic rx_pin;
    logic obs_pin;
  } scec_src_t;

  // Software preselection of observation inputs (index 0..3)
  typedef struct packed {
    logic [1:0] first_sel;
    logic [1:0] second_sel;
  } scec_obs_pre_t;

  // Path enables driven to the signal chains
  typedef struct packed {
    logic [3:0] rx;
    logic [3:0] tx;
    logic [3:0] obs;
    logic [1:0] loopback;
  } scec_enables_t;

  // Control state machine
  typedef enum logic [1:0] {
    SCEC_ST_REG = 2'b01,
    SCEC_ST_MIXED = 2'b10
  } scec_state_t;

endpackage

// [design/scec_obs_pin_decode.sv]
// Purpose: Decode observation control pins into observation input enables.
// Assumes: Pins synchronous to the reference clock.
// Notes: Purely combinational; the top registers the result.
`include "scec_consts.svh"

module scec_obs_pin_decode
  import scec_pkg::*;
(
  input wire scec_obs_mode_t mode_i,
  input wire scec_obs_pre_t pre_i,
  input wire logic pin_first_i,
  input wire logic pin_second_i,
  input wire logic pin_third_i,
  input wire logic pin_fourth_i,
  output logic [3:0] obs_en_o
);

  function automatic logic [3:0] scec_onehot(input logic [1:0] idx);
    scec_onehot = 4'h1 << idx;
  endfunction

  always_comb
  begin
    obs_en_o = 4'h0;
    case (mode_i)
      SCEC_OBS_SINGLE_1PIN:
      begin
        // Low disables every observation path
        if (pin_first_i)
        begin
          obs_en_o = scec_onehot(pre_i.first_sel); // [RULE8]
        end
      end
      SCEC_OBS_SINGLE_2PIN:
      begin
        if (pin_first_i)
        begin
          obs_en_o = pin_second_i ? scec_onehot(pre_i.first_sel)
                                  : scec_onehot(pre_i.second_sel); // [RULE9]
        end
      end
      SCEC_OBS_SINGLE_3PIN:
      begin
        if (pin_first_i)
        begin
          obs_en_o = scec_onehot({pin_third_i, pin_second_i}); // [RULE10] [RULE11]
        end
      end
      SCEC_OBS_DUAL_2PIN:
      begin
        obs_en_o = (pin_first_i ? scec_onehot(pre_i.first_sel) : 4'h0)
                 | (pin_third_i ? scec_onehot(pre_i.second_sel) : 4'h0); // [RULE14]
      end
      SCEC_OBS_DUAL_4PIN:
      begin
        // First pin covers inputs one/two, third pin inputs three/four
        obs_en_o = (pin_first_i ? scec_onehot({1'b0, pin_second_i}) : 4'h0)
                 | (pin_third_i ? scec_onehot({1'b1, pin_fourth_i}) : 4'h0); // [RULE15]
      end
      default:
      begin
        obs_en_o = 4'h0;
      end
    endcase
  end

endmodule

// [testbench/scec_checker.sv]
// Purpose: Port checker for scec_top
// Assumes: Enables register one cycle after their cause
// Notes: Dual observation modes are left to the bench
module scec_checker
  import scec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic mask_write_i,
  input wire logic [11:0] receive_path_mask_i,
  input wire scec_obs_mode_t obs_mode_i,
  input wire scec_obs_pre_t obs_pre_i,
  input wire scec_pins_t pins_i,
  input wire scec_enables_t enables_o,
  input wire scec_src_t src_o,
  input wire logic [11:0] receive_path_mask_o,
  input wire logic [3:0] transmit_path_mask_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ----
  // Assertions and covers
  // ----
  a_rx_mask_load: assert property ($past(resetn_i) && $past(mask_write_i) |->
    receive_path_mask_o[3:0] == ($past(src_o.rx_pin) ? $past(receive_path_mask_o[3:0])
    : $past(receive_path_mask_i[3:0]))) else $error("rx mask load wrong");
  a_mask_hold: assert property (!$past(mask_write_i) |->
    $stable(receive_path_mask_o) && $stable(transmit_path_mask_o)) else $error("mask moved");
  a_rx_reg_en: assert property (!$past(src_o.rx_pin) |->
    enables_o.rx == $past(receive_path_mask_o[3:0])) else $error("rx enables wrong");
  a_obs_reg_en: assert property (!$past(src_o.obs_pin) |->
    {enables_o.loopback, enables_o.obs} == $past(receive_path_mask_o[9:4]))
    else $error("obs enables wrong");
  a_tx_reg_en: assert property (!$past(src_o.tx_pin) |->
    enables_o.tx == $past(transmit_path_mask_o)) else $error("tx enables wrong");
  a_rx_pin_en: assert property ($past(src_o.rx_pin) |->
    enables_o.rx == $past(pins_i.rx_en)) else $error("rx pin not followed");
  a_tx_pin_en: assert property ($past(src_o.tx_pin) |->
    enables_o.tx == $past(pins_i.tx_en)) else $error("tx pin not followed");
  a_one_pin_obs: assert property ($past(src_o.obs_pin) &&
    $past(obs_mode_i) == SCEC_OBS_SINGLE_1PIN |-> enables_o.obs ==
    ($past(pins_i.obs_ctrl_pin_first) ? 4'h1 << $past(obs_pre_i.first_sel) : 4'h0))
    else $error("one pin obs wrong");
  a_three_pin_obs: assert property ($past(src_o.obs_pin) &&
    $past(obs_mode_i) == SCEC_OBS_SINGLE_3PIN |-> enables_o.obs ==
    ($past(pins_i.obs_ctrl_pin_first) ? 4'h1 << {$past(pins_i.obs_ctrl_pin_third),
    $past(pins_i.obs_ctrl_pin_second)} : 4'h0)) else $error("three pin obs wrong");
  a_reset_reg: assert property ($rose(resetn_i) |-> src_o == 3'h0)
    else $error("not register control after reset");
  c_all_off: cover property (mask_write_i && receive_path_mask_i == 12'h000);
  c_all_pin: cover property (src_o == 3'h7);
  c_three_pin: cover property (src_o.obs_pin && obs_mode_i == SCEC_OBS_SINGLE_3PIN);
endmodule

bind scec_top scec_checker u_chk (
  .ref_clk_i, .resetn_i, .mask_write_i, .receive_path_mask_i, .obs_mode_i, .obs_pre_i,
  .pins_i, .enables_o, .src_o, .receive_path_mask_o, .transmit_path_mask_o
);

// [testbench/scec_bb_model.sv]
// Purpose: Baseband controller driving the chain enable pins
// Assumes: Levels change only at the falling edge
// Notes: Holds its last levels while stall_i is high
module scec_bb_model
  import scec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic stall_i,
  input wire scec_pins_t req_i,
  output scec_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(negedge ref_clk_i)
    if (!stall_i) pins_o <= req_i;
endmodule

// [testbench/testbench.sv]
// Purpose: Self-checking bench for scec_top
// Assumes: Inputs change at the falling edge
// Notes: A cycle model in the bench predicts every output
module testbench
  import scec_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mask_write_i = 1'b0;
  logic src_write_i = 1'b0;
  logic stall = 1'b0;
  logic [11:0] rm_i = 12'h000;
  logic [3:0] tm_i = 4'h0;
  scec_src_t src_i = '0;
  scec_obs_mode_t mode_i = SCEC_OBS_SINGLE_1PIN;
  scec_obs_pre_t pre_i = '0;
  scec_pins_t req = '0;
  scec_pins_t pins;
  scec_enables_t en_o, x_en;
  scec_src_t src_o, x_src;
  logic [11:0] rm_o, x_rm;
  logic [3:0] tm_o, x_tm;
  logic pc_o;
  int error_cnt = 0;
  int checked = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  scec_bb_model u_bb (.ref_clk_i, .stall_i(stall), .req_i(req), .pins_o(pins));
  scec_top u_dut (
    .ref_clk_i, .resetn_i, .mask_write_i, .receive_path_mask_i(rm_i),
    .transmit_path_mask_i(tm_i), .src_write_i, .src_i, .obs_mode_i(mode_i),
    .obs_pre_i(pre_i), .pins_i(pins), .enables_o(en_o), .src_o,
    .receive_path_mask_o(rm_o), .transmit_path_mask_o(tm_o), .pin_control_o(pc_o)
  );
  function automatic logic [3:0] obs_x(scec_obs_mode_t m, scec_obs_pre_t p, scec_pins_t q);
    logic [3:0] a, b;
    logic f, s, t, u;
    {f, s, t, u} = q[3:0];
    a = 4'h1 << p.first_sel;
    b = 4'h1 << p.second_sel;
    case (m)
      SCEC_OBS_SINGLE_1PIN: return f ? a : 4'h0;
      SCEC_OBS_SINGLE_2PIN: return f ? (s ? a : b) : 4'h0;
      SCEC_OBS_SINGLE_3PIN: return f ? 4'h1 << {t, s} : 4'h0;
      SCEC_OBS_DUAL_2PIN: return (f ? a : 4'h0) | (t ? b : 4'h0);
      SCEC_OBS_DUAL_4PIN: return {t & u, t & ~u, f & s, f & ~s};
      default: return 4'h0;
    endcase
  endfunction
  // Model reads the old state first, as the design's registers do
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      x_en = '0;
      x_src = '0;
      x_rm = '0;
      x_tm = '0;
    end
    else
    begin
      x_en.rx = x_src.rx_pin ? pins.rx_en : x_rm[3:0];
      x_en.tx = x_src.tx_pin ? pins.tx_en : x_tm;
      x_en.obs = x_src.obs_pin ? obs_x(mode_i, pre_i, pins) : x_rm[7:4];
      x_en.loopback = x_src.obs_pin ? 2'h0 : x_rm[9:8];
      if (mask_write_i && !x_src.rx_pin) x_rm[3:0] = rm_i[3:0];
      if (mask_write_i && !x_src.obs_pin) x_rm[11:4] = rm_i[11:4];
      if (mask_write_i && !x_src.tx_pin) x_tm = tm_i;
      if (src_write_i) x_src = src_i;
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step(input logic w, input logic [11:0] r, input logic [3:0] t);
    @(negedge ref_clk_i);
    checked++;
    if ({en_o, src_o, rm_o, tm_o, pc_o} !== {x_en, x_src, x_rm, x_tm, |x_src})
    begin
      error_cnt++;
      $display("unexpected at %0t: enables %h want %h", $time, en_o, x_en);
    end
    mask_write_i = w;
    rm_i = r;
    tm_i = t;
  endtask
  initial
  begin
    void'($urandom(89));
    repeat (3) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    step(1'b1, 12'h0FF, 4'hF);
    for (int i = 0; i < 4; i++) step(1'b1, 12'h300, 4'h1 << i);
    step(1'b1, 12'h000, 4'h0);
    repeat (3) step(1'b0, 12'hFFF, 4'h0);
    src_i = 3'h7;
    src_write_i = 1'b1;
    step(1'b1, 12'hFFF, 4'hF);
    src_write_i = 1'b0;
    repeat (3) step(1'b1, 12'h000, 4'h0);
    $display("test corners done");
    for (int i = 0; i < 3000; i++)
    begin
      resetn_i = (i != 1500);
      src_write_i = resetn_i && ($urandom_range(7, 0) == 0);
      src_i = scec_src_t'($urandom);
      mode_i = scec_obs_mode_t'($urandom_range(7, 0));
      pre_i = scec_obs_pre_t'($urandom);
      req <= scec_pins_t'($urandom);
      stall <= 1'($urandom);
      step(resetn_i & 1'($urandom), 12'($urandom), 4'($urandom));
    end
    $display("test random done");
    end_sim();
  end
endmodule
